/* otc_regs.svh */
// register map, field positions, reset values and capture width for the trim and
// clock select block; assumes a 32-bit apb slave with word-aligned registers
`ifndef OTC_REGS_SVH
`define OTC_REGS_SVH
// byte offsets
`define OTC_TRIM_OFS     8'h00
`define OTC_CKCS_OFS     8'h04
`define OTC_PROT_OFS     8'h08
`define OTC_DIV_OFS      8'h0C
`define OTC_IRQ_STAT_OFS 8'h10
`define OTC_IRQ_MASK_OFS 8'h14
`define OTC_CAPT_OFS     8'h18
`define OTC_PORT_OFS     8'h1C
// clock control / status fields
`define OTC_CK_PFUNC_HI  7
`define OTC_CK_PFUNC_LO  6
`define OTC_CK_RSVD5     5
`define OTC_CK_FORCE     4
`define OTC_CK_IRQ_EN    3
`define OTC_CK_IRQ_FLAG  2
`define OTC_CK_ONE       1
`define OTC_CK_STATUS    0
// trim protect fields
`define OTC_PR_WRI       7
`define OTC_PR_PRWE      6
`define OTC_PR_LOCK      5
`define OTC_PR_TWE       4
// reset values
`define OTC_TRIM_RST     8'h00
`define OTC_TRIM_UNDEF   8'hFF
`define OTC_PROT_ONES    8'h8F
`define OTC_CKCS_ONES    8'h02
// irq status bits
`define OTC_IRQ_SWITCH   0
`define OTC_IRQ_CAPT     1
// capture counter width
`define OTC_CAPT_W       16
`endif

/* otc_pkg.sv */
// types shared by the trim and clock select block
// assumes otc_regs.svh holds the numeric constants
package otc_pkg;
  // shared pin assignment modes
  typedef enum logic [1:0] {
    OTC_PF_GPIO   = 2'b00,
    OTC_PF_EXTCLK = 2'b01,
    OTC_PF_CLOCK_OUTPUT_PIN = 2'b10,
    OTC_PF_XTAL   = 2'b11
  } otc_pfunc_type;
  // system clock source states
  typedef enum logic {OTC_SRC_OSC, OTC_SRC_EXT} otc_src_type;
endpackage

/* otc_capture.sv */
// input capture sampler used while trimming the on-chip oscillator
// assumes the reference pin is synchronous to the oscillator clock
`timescale 1ns/100ps
`include "otc_regs.svh"
module otc_capture #(
  parameter int CW = `OTC_CAPT_W
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_sync_b,
  // reference pulse in
  input  wire logic          ref_pin,
  // measured period
  output logic [CW-1:0]      period_ff,
  output logic               done_ff
);
  // -------------------------------------------------------------
  // edge sampling and period count
  // -------------------------------------------------------------
  logic          ref_d_ff;     // last sample of the reference pin
  logic [CW-1:0] cnt_ff;       // oscillator cycles since last edge
  wire           rise = ref_pin & ~ref_d_ff;
  // the pin is only seen at clock edges, so a count is off by one either way
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ref_d_ff  <= 1'b0;
      cnt_ff    <= '0;
      period_ff <= '0;
      done_ff   <= 1'b0;
    end else begin
      ref_d_ff <= ref_pin;
      done_ff  <= rise;
      if (rise) begin
        period_ff <= cnt_ff;  // latch the interval just closed
        cnt_ff    <= CW'(1);
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end
endmodule // otc_capture

/* otc_top.sv */
// on-chip oscillator trim and system clock select, with apb register access
// assumes an apb master on core_clk and pins synchronous to core_clk
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "otc_regs.svh"
module otc_top
  import otc_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b0  // 1: factory trim from nonvolatile store
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // factory trim from nonvolatile memory
  input  wire logic [7:0]  nvm_trim_value,
  // oscillator controls
  output logic [7:0]       osc_trim_value,
  output logic [1:0]       osc_divider_sel,
  output logic             sys_clk_ext_sel,
  output logic             oscillator_in_en,
  output logic             xtal_amp_en,
  // trimming reference (timer capture pin)
  input  wire logic        trim_ref_pin,
  // shared port pins
  input  wire logic        shared_port_pin_lo_in,
  output logic             shared_port_pin_lo_out,
  output logic             shared_port_pin_lo_oe_b,
  input  wire logic        shared_port_pin_hi_in,
  output logic             shared_port_pin_hi_out,
  output logic             shared_port_pin_hi_oe_b,
  // interrupt
  output logic             irq
);
  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rst_s1_ff;   // first stage, read only by the second
  logic rst_sync_b;  // synchronised reset used by everything else
  // release is delayed two edges so no flop leaves reset on a partial cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff  <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_sync_b <= rst_s1_ff;
    end
  end

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  logic        pready_ff;   // answer flag, one wait state
  logic        pslverr_ff;  // unmapped address answer
  logic [31:0] prdata_ff;   // read data held for the master
  // decode an offset against the current address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction
  wire access   = psel & penable;
  wire commit   = access & pready_ff;         // edge at which a transfer completes
  wire wr_go    = commit & pwrite & ~pslverr_ff;
  wire rd_go    = commit & ~pwrite & ~pslverr_ff;
  wire sel_trim = hit(paddr, `OTC_TRIM_OFS);
  wire sel_ckcs = hit(paddr, `OTC_CKCS_OFS);
  wire sel_prot = hit(paddr, `OTC_PROT_OFS);
  wire sel_div  = hit(paddr, `OTC_DIV_OFS);
  wire sel_stat = hit(paddr, `OTC_IRQ_STAT_OFS);
  wire sel_mask = hit(paddr, `OTC_IRQ_MASK_OFS);
  wire sel_capt = hit(paddr, `OTC_CAPT_OFS);
  wire sel_port = hit(paddr, `OTC_PORT_OFS);
  wire mapped   = sel_trim | sel_ckcs | sel_prot | sel_div | sel_stat | sel_mask
                | sel_capt | sel_port;
  wire [7:0] wd = pwdata[7:0];

  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic [7:0]  trim_ff;        // oscillator trim code
  logic        loaded_ff;      // factory trim copied once
  logic        prwe_ff;        // protect write enable
  logic        lock_ff;        // trim lock, sticky until reset
  logic        twe_ff;         // trim write enable
  logic [1:0]  div_ff;         // oscillator divider select
  logic [1:0]  pfunc_ff;       // shared pin function
  logic        rsvd5_ff;       // spare read/write bit
  logic        force_ff;       // requested clock source
  logic        irq_en_ff;      // clock switch irq enable
  logic        flag_ff;        // clock switch flag
  logic        flag_seen_ff;   // flag read as one since last set
  otc_src_type src_ff;         // running clock source
  logic [1:0]  stat_ff;        // sticky irq status
  logic [1:0]  mask_ff;        // irq mask
  logic [1:0]  port_dout_ff;   // port output data, lo in bit 0
  logic [1:0]  port_dir_ff;    // port direction, 1 drives
  logic        clock_output_pin_ff;      // divided clock for the output pin
  logic [`OTC_CAPT_W-1:0] capt_period;
  logic        capt_done;

  // -------------------------------------------------------------
  // next values
  // -------------------------------------------------------------
  wire prot_wr  = wr_go & sel_prot & ~wd[`OTC_PR_WRI];  // write needs write-inhibit bit at 0
  wire trim_ok  = ~lock_ff & twe_ff;
  wire trim_wr  = wr_go & sel_trim & trim_ok & ~FLASH_VARIANT;
  wire ckcs_wr  = wr_go & sel_ckcs;
  wire div_wr   = wr_go & sel_div & (src_ff == OTC_SRC_OSC);
  // only the upper six trim bits store; the low two stay zero
  wire [7:0] nxt_trim = trim_wr ? {wd[7:2], 2'b00} : trim_ff;
  // switching back to the oscillator is the flag event
  wire sw_event = (src_ff == OTC_SRC_EXT) & ~force_ff;
  // clearing needs a read of one first; a coincident set wins
  wire flag_clr = ckcs_wr & ~wd[`OTC_CK_IRQ_FLAG] & flag_seen_ff;
  wire nxt_flag = sw_event | (flag_ff & ~flag_clr);
  wire flag_rd1 = rd_go & sel_ckcs & flag_ff;
  // interrupt events: switch only when enabled, capture always
  wire [1:0] ev = {capt_done, sw_event & irq_en_ff};
  wire [1:0] stat_clr = (rd_go & sel_stat) ? 2'b11 : 2'b00;
  wire [1:0] nxt_stat = ev | (stat_ff & ~stat_clr);
  // signed trim step for the oscillator model: sign in bit 7, step of four
  wire signed [5:0] trim_step = $signed(trim_ff[7:2]);
  // read view of the trim register
  wire [7:0] trim_rd = FLASH_VARIANT ? `OTC_TRIM_UNDEF : trim_ff;
  wire [7:0] ckcs_rd = {pfunc_ff, rsvd5_ff, force_ff, irq_en_ff, flag_ff, 1'b0, src_ff}
                     | `OTC_CKCS_ONES;                    // status in bit 0
  wire [7:0] prot_rd = {1'b0, prwe_ff, lock_ff, twe_ff, 4'h0} | `OTC_PROT_ONES;
  wire [31:0] nxt_rdata =
      sel_trim ? {24'h0, trim_rd} :
      sel_ckcs ? {24'h0, ckcs_rd} :
      sel_prot ? {24'h0, prot_rd} :
      sel_div  ? {30'h0, div_ff} :
      sel_stat ? {30'h0, stat_ff} :
      sel_mask ? {30'h0, mask_ff} :
      sel_capt ? {16'h0, capt_period} :
      sel_port ? {24'h0, 2'b00, port_dir_ff, 2'b00, shared_port_pin_hi_in,
                  shared_port_pin_lo_in} :
                 32'h0;

  // -------------------------------------------------------------
  // apb answer
  // -------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, data registered
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else if (access & ~pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~mapped;            // unmapped: error, write ignored
      prdata_ff  <= pwrite ? 32'h0 : nxt_rdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // trim register
  // -------------------------------------------------------------
  // rom variant holds zero from reset; flash variant copies the factory code
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      trim_ff   <= `OTC_TRIM_RST;
      loaded_ff <= 1'b0;
    end else if (FLASH_VARIANT & ~loaded_ff) begin
      trim_ff   <= nvm_trim_value;      // first edge after release
      loaded_ff <= 1'b1;
    end else begin
      trim_ff   <= nxt_trim;            // reaches the oscillator one edge later through trim_out_ff
      loaded_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // trim protect register
  // -------------------------------------------------------------
  // lock only ever sets; a reset is the one way out
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prwe_ff <= 1'b0;
      lock_ff <= 1'b0;
      twe_ff  <= 1'b0;
    end else if (prot_wr) begin
      prwe_ff <= wd[`OTC_PR_PRWE];
      lock_ff <= lock_ff | (prwe_ff & wd[`OTC_PR_LOCK]);
      twe_ff  <= prwe_ff ? wd[`OTC_PR_TWE] : twe_ff;
    end
  end

  // -------------------------------------------------------------
  // divider select
  // -------------------------------------------------------------
  // a write while on the external clock is dropped silently
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_ff <= 2'b00;
    end else if (div_wr) begin
      div_ff <= wd[1:0];
    end
  end

  // -------------------------------------------------------------
  // clock control register
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pfunc_ff  <= OTC_PF_GPIO;
      rsvd5_ff  <= 1'b0;
      force_ff  <= 1'b0;                // oscillator after reset
      irq_en_ff <= 1'b0;
    end else if (ckcs_wr) begin
      pfunc_ff  <= wd[`OTC_CK_PFUNC_HI:`OTC_CK_PFUNC_LO];
      rsvd5_ff  <= wd[`OTC_CK_RSVD5];
      force_ff  <= wd[`OTC_CK_FORCE];
      irq_en_ff <= wd[`OTC_CK_IRQ_EN];
    end
  end

  // -------------------------------------------------------------
  // clock source and switch flag
  // -------------------------------------------------------------
  // the source follows the force bit one edge later, so only software moves it
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      src_ff       <= OTC_SRC_OSC;
      flag_ff      <= 1'b0;
      flag_seen_ff <= 1'b0;
    end else begin
      src_ff       <= force_ff ? OTC_SRC_EXT : OTC_SRC_OSC;
      flag_ff      <= nxt_flag;
      flag_seen_ff <= (flag_seen_ff | flag_rd1) & ~flag_clr & ~sw_event;
    end
  end

  // -------------------------------------------------------------
  // interrupt status and mask
  // -------------------------------------------------------------
  // a read clears status, but an event in the same cycle still lands
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stat_ff <= 2'b00;
      mask_ff <= 2'b00;
    end else begin
      stat_ff <= nxt_stat;
      if (wr_go & sel_mask) begin
        mask_ff <= wd[1:0];
      end
    end
  end

  // -------------------------------------------------------------
  // shared pins
  // -------------------------------------------------------------
  // port data and direction; steer each pin only while its pin function leaves it free
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      port_dout_ff <= 2'b00;
      port_dir_ff  <= 2'b00;
    end else if (wr_go & sel_port) begin
      port_dout_ff <= wd[1:0];
      port_dir_ff  <= wd[5:4];
    end
  end

  wire [1:0] pf      = pfunc_ff;
  wire       hi_gpio = ~pf[1];                   // hi pin free unless bit 1 set
  wire       lo_gpio = ~pf[0];                   // lo pin free unless bit 0 set
  wire       hi_clko = (pf == OTC_PF_CLOCK_OUTPUT_PIN);

  // every pin output is registered; the clock output toggles at half rate,
  // which is the cheapest clean copy of the system clock in one domain
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clock_output_pin_ff               <= 1'b0;
      shared_port_pin_lo_out  <= 1'b0;
      shared_port_pin_lo_oe_b <= 1'b1;
      shared_port_pin_hi_out  <= 1'b0;
      shared_port_pin_hi_oe_b <= 1'b1;
      oscillator_in_en        <= 1'b0;
      xtal_amp_en             <= 1'b0;
    end else begin
      clock_output_pin_ff               <= ~clock_output_pin_ff;
      // lo pin: port or oscillator input
      shared_port_pin_lo_out  <= port_dout_ff[0];
      shared_port_pin_lo_oe_b <= ~(lo_gpio & port_dir_ff[0]);
      // hi pin: port, clock out or crystal output
      shared_port_pin_hi_out  <= hi_clko ? clock_output_pin_ff : port_dout_ff[1];
      shared_port_pin_hi_oe_b <= ~(hi_clko | (hi_gpio & port_dir_ff[1]));
      oscillator_in_en        <= pf[0];
      xtal_amp_en             <= (pf == OTC_PF_XTAL);
    end
  end

  // -------------------------------------------------------------
  // oscillator controls and irq
  // -------------------------------------------------------------
  logic [7:0] trim_out_ff;
  logic [1:0] div_out_ff;
  logic       ext_sel_ff;
  logic       irq_ff;
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      trim_out_ff <= `OTC_TRIM_RST;
      div_out_ff  <= 2'b00;
      ext_sel_ff  <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      trim_out_ff <= {trim_step, trim_ff[1:0]};  // signed code to oscillator
      div_out_ff  <= div_ff;
      ext_sel_ff  <= (src_ff == OTC_SRC_EXT);
      irq_ff      <= |(nxt_stat & mask_ff);
    end
  end

  // -------------------------------------------------------------
  // trimming capture
  // -------------------------------------------------------------
  otc_capture u_capture (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .ref_pin    (trim_ref_pin),
    .period_ff  (capt_period),
    .done_ff    (capt_done)
  );

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign osc_trim_value  = trim_out_ff;
  assign osc_divider_sel = div_out_ff;
  assign sys_clk_ext_sel = ext_sel_ff;
  assign irq             = irq_ff;
endmodule // otc_top

/* otc_asserts.sv */
// concurrent checks on the ports of the trim and clock select top
// assumes apb on core_clk and the rom build unless FLASH_VARIANT is set
`timescale 1ns/100ps
`include "otc_regs.svh"
module otc_asserts #(
  parameter bit FLASH_VARIANT = 1'b0  // 1: factory trim build
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // oscillator and pins
  input wire logic [7:0]  osc_trim_value,
  input wire logic [1:0]  osc_divider_sel,
  input wire logic        sys_clk_ext_sel,
  input wire logic        oscillator_in_en,
  input wire logic        xtal_amp_en,
  input wire logic        shared_port_pin_lo_oe_b,
  input wire logic        irq
);
  // ----------------------------------------
  // helper: cycles since a clock control write
  // ----------------------------------------
  logic [3:0] since_ck_ff;   // saturates so a stale write never looks recent
  logic [3:0] nxt_since_ck;  // next count
  wire        ck_wr = psel && penable && pready && pwrite && paddr == `OTC_CKCS_OFS;
  wire        trim_wr = psel && penable && pready && pwrite && paddr == `OTC_TRIM_OFS;
  assign nxt_since_ck = ck_wr ? 4'h0 : (since_ck_ff == 4'hF ? 4'hF : since_ck_ff + 4'h1);
  // count restarts on every committed clock control write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) since_ck_ff <= 4'hF;
    else since_ck_ff <= nxt_since_ck;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ready_one_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  trim_low_zero_a: assert property (!FLASH_VARIANT |-> osc_trim_value[1:0] == 2'b00)
    else $error("trim low bits not zero");
  trim_on_write_a: assert property (!FLASH_VARIANT && $changed(osc_trim_value) |-> $past(trim_wr, 2))
    else $error("trim moved without a write");
  xtal_pins_in_a: assert property (xtal_amp_en |-> oscillator_in_en && shared_port_pin_lo_oe_b)
    else $error("crystal mode pins wrong");
  ext_on_cmd_a: assert property ($rose(sys_clk_ext_sel) |-> since_ck_ff <= 4'h3)
    else $error("external clock without command");
  div_hold_ext_a: assert property (sys_clk_ext_sel && $past(sys_clk_ext_sel) |-> $stable(osc_divider_sel))
    else $error("divider moved on external clock");
  status_read_a: assert property (pready && !pwrite && !pslverr && paddr == `OTC_CKCS_OFS |->
    prdata[`OTC_CK_STATUS] == sys_clk_ext_sel && prdata[`OTC_CK_ONE])
    else $error("clock status read wrong");
  // main scenarios reached
  irq_seen_c: cover property ($rose(irq));
  xtal_seen_c: cover property ($rose(xtal_amp_en));
  err_seen_c: cover property (pslverr);
endmodule // otc_asserts

bind otc_top otc_asserts #(.FLASH_VARIANT(FLASH_VARIANT)) otc_asserts_inst (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_trim_value(osc_trim_value), .osc_divider_sel(osc_divider_sel),
  .sys_clk_ext_sel(sys_clk_ext_sel), .oscillator_in_en(oscillator_in_en),
  .xtal_amp_en(xtal_amp_en), .shared_port_pin_lo_oe_b(shared_port_pin_lo_oe_b), .irq(irq));

/* otc_ext_src.sv */
// external clock source and reference pulse generator on the shared pins
// assumes pin levels are resolved here from the block's enables
`timescale 1ns/100ps
module otc_ext_src #(
  parameter int REF_HALF = 10  // reference half period in clocks
) (
  // clock
  input wire logic core_clk,
  // pins as driven by the block
  input wire logic lo_out,
  input wire logic lo_oe_b,
  input wire logic hi_out,
  input wire logic hi_oe_b,
  input wire logic ext_in_en,
  // levels seen at the pins
  output logic     lo_in,
  output logic     hi_in,
  output logic     ref_pulse
);
  logic ext_ff = 1'b0;  // external clock, stands still unless taken
  logic flt_ff = 1'b0;  // released pin shows a changing pattern, not a stale level
  logic ref_ff = 1'b0;  // reference square wave
  int   cnt_ff = 0;     // half period counter
  // sources run from the core clock for a fixed phase relation
  always_ff @(posedge core_clk) begin
    flt_ff <= ~flt_ff;
    ext_ff <= ext_in_en ? ~ext_ff : 1'b0;
    cnt_ff <= (cnt_ff == REF_HALF - 1) ? 0 : cnt_ff + 1;
    if (cnt_ff == REF_HALF - 1) ref_ff <= ~ref_ff;
  end
  // the block wins while it drives; otherwise this side does
  assign lo_in = !lo_oe_b ? lo_out : (ext_in_en ? ext_ff : flt_ff);
  assign hi_in = !hi_oe_b ? hi_out : flt_ff;
  assign ref_pulse = ref_ff;
endmodule // otc_ext_src

/* test_osc_trim_clock_select.sv */
// self-checking bench: apb register sequences against the rom build
// assumes otc_ext_src on the pins and a 25 MHz core clock
`timescale 1ns/100ps
`include "otc_regs.svh"
module test_osc_trim_clock_select;
  import otc_pkg::*;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, osc_trim_value, tv;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  osc_divider_sel, m;
  logic        ext_sel, osc_in_en, xtal_en, rerr, t;
  logic        lo_in, lo_out, lo_oe_b, hi_in, hi_out, hi_oe_b, ref_pin;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  otc_top #(.FLASH_VARIANT(1'b0)) otc_top_inst (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_trim_value(8'h00),
    .osc_trim_value(osc_trim_value), .osc_divider_sel(osc_divider_sel),
    .sys_clk_ext_sel(ext_sel), .oscillator_in_en(osc_in_en), .xtal_amp_en(xtal_en),
    .trim_ref_pin(ref_pin), .shared_port_pin_lo_in(lo_in), .shared_port_pin_lo_out(lo_out),
    .shared_port_pin_lo_oe_b(lo_oe_b), .shared_port_pin_hi_in(hi_in),
    .shared_port_pin_hi_out(hi_out), .shared_port_pin_hi_oe_b(hi_oe_b), .irq(irq));
  otc_ext_src otc_ext_src_inst (.core_clk(core_clk), .lo_out(lo_out), .lo_oe_b(lo_oe_b),
    .hi_out(hi_out), .hi_oe_b(hi_oe_b), .ext_in_en(osc_in_en), .lo_in(lo_in),
    .hi_in(hi_in), .ref_pulse(ref_pin));
  // 40 ns clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ends the run once; every path out comes here
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard: the run needs under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; ready sampled at rising edges
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    apb(1'b0, adr, 32'h0000_0000);
    chk(what, rdat, exp);
  endtask
  // let outputs land, then look mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    // reset state
    rchk("trim reset", `OTC_TRIM_OFS, 32'h0000_0000);
    rchk("ckcs reset", `OTC_CKCS_OFS, 32'h0000_0002);
    chk("ext sel reset", {31'h0, ext_sel}, 32'h0000_0000);
    $display("test reset done");
    // trim guarded, then signed codes in steps of four, then locked
    apb(1'b1, `OTC_TRIM_OFS, 32'h0000_007F);
    rchk("trim guarded", `OTC_TRIM_OFS, 32'h0000_0000);
    apb(1'b1, `OTC_PROT_OFS, 32'h0000_0040);
    apb(1'b1, `OTC_PROT_OFS, 32'h0000_0050);
    for (int i = 0; i < 5; i++) begin
      tv = (i == 0) ? 8'h80 : (i == 1) ? 8'hFC : (i == 2) ? 8'h04 : (i == 3) ? 8'h00 : 8'h7F;
      apb(1'b1, `OTC_TRIM_OFS, {24'h0, tv});
      rchk("trim code", `OTC_TRIM_OFS, {24'h0, tv & 8'hFC});
      settle(0);
      chk("trim out", {24'h0, osc_trim_value}, {24'h0, tv & 8'hFC});
    end
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rchk("trim rst", `OTC_TRIM_OFS, 32'h0000_0000);
    apb(1'b1, `OTC_PROT_OFS, 32'h0000_0040);
    apb(1'b1, `OTC_PROT_OFS, 32'h0000_0050);
    apb(1'b1, `OTC_TRIM_OFS, 32'h0000_007C);
    apb(1'b1, `OTC_PROT_OFS, 32'h0000_0070);
    apb(1'b1, `OTC_TRIM_OFS, 32'h0000_0004);
    rchk("trim locked", `OTC_TRIM_OFS, 32'h0000_007C);
    rchk("protect", `OTC_PROT_OFS, 32'h0000_00FF);
    $display("test trim done");
    // general port use, then each pin function
    apb(1'b1, `OTC_PORT_OFS, 32'h0000_0031);
    settle(1);
    chk("port drive", {28'h0, lo_out, hi_out, lo_oe_b, hi_oe_b}, 32'h0000_0008);
    rchk("port read", `OTC_PORT_OFS, 32'h0000_0031);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      apb(1'b1, `OTC_CKCS_OFS, {24'h0, m, 6'h00});
      settle(2);
      chk("pin mode", {28'h0, osc_in_en, xtal_en, lo_oe_b, hi_oe_b},
          {28'h0, m[0], m == 2'b11, m[0], m == 2'b11});
      if (m == 2'b10) begin
        t = hi_out;
        settle(0);
        chk("clock out", {31'h0, hi_out}, {31'h0, ~t});
      end
    end
    $display("test pins done");
    // switch out to the external clock and back
    apb(1'b1, `OTC_IRQ_MASK_OFS, 32'h0000_0001);
    apb(1'b1, `OTC_CKCS_OFS, 32'h0000_00D8);
    settle(3);
    chk("ext sel on", {31'h0, ext_sel}, 32'h0000_0001);
    rchk("ckcs ext", `OTC_CKCS_OFS, 32'h0000_00DB);
    apb(1'b1, `OTC_DIV_OFS, 32'h0000_0003);
    rchk("div refused", `OTC_DIV_OFS, 32'h0000_0000);
    apb(1'b1, `OTC_CKCS_OFS, 32'h0000_00C8);
    settle(3);
    chk("ext sel off", {31'h0, ext_sel}, 32'h0000_0000);
    chk("irq up", {31'h0, irq}, 32'h0000_0001);
    rchk("ckcs flag", `OTC_CKCS_OFS, 32'h0000_00CE);
    apb(1'b0, `OTC_IRQ_STAT_OFS, 32'h0000_0000);
    chk("irq stat", rdat & 32'h0000_0001, 32'h0000_0001);
    settle(1);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `OTC_CKCS_OFS, 32'h0000_00C8);
    rchk("flag cleared", `OTC_CKCS_OFS, 32'h0000_00CA);
    apb(1'b1, `OTC_DIV_OFS, 32'h0000_0002);
    rchk("div taken", `OTC_DIV_OFS, 32'h0000_0002);
    $display("test switch done");
    // reference period of 20 clocks, one either way allowed
    apb(1'b0, `OTC_CAPT_OFS, 32'h0000_0000);
    chk("capture", {31'h0, rdat[15:0] >= 16'd19 && rdat[15:0] <= 16'd21}, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", {31'h0, rerr}, 32'h0000_0001);
    chk("unmapped data", rdat, 32'h0000_0000);
    $display("test misc done");
    print_verdict();
  end
endmodule // test_osc_trim_clock_select
